/* File: ldcrc_chk.sv */
`timescale 1ns/100ps
module ldcrc_chk
   import ldcrc_pkg::*;
#(
   parameter int NROW = 44
)
(
   // clock and reset
   input wire logic                   pclk,
   input wire logic                   presetn,
   // apb
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic [APB_AW-1:0]      paddr,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr,
   // led drive and state
   input wire logic [NROW-1:0]        row_out,
   input wire logic [NUM_COMMONS-1:0] common_lines_out,
   input wire logic [NUM_COMMONS-1:0] common_lines_oe,
   input wire logic                   osc_enable,
   input wire logic                   timebase_run,
   input wire logic                   power_down,
   input wire logic                   blink_enable,
   input wire logic [3:0]             dim_level
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // *****
   // state after reset and while stopped
   // *****
   reset_state_a:
      assert property ($rose(presetn) |-> power_down && !osc_enable && !timebase_run && !blink_enable
                       && dim_level == 4'hF && common_lines_oe == '0 && row_out == '0)
      else $error("outputs not idle after reset");
   one_common_a:
      assert property ($onehot0(common_lines_oe)) else $error("more than one common enabled");
   common_sink_a:
      assert property (common_lines_out == '0) else $error("common drive level not low");
   pdown_stop_a:
      assert property (power_down |-> !osc_enable && !timebase_run) else $error("clock runs in power-down");
   osc_runs_a:
      assert property (osc_enable |-> timebase_run) else $error("oscillator on but clock stopped");
   blank_stop_a:
      assert property (!timebase_run [*3] |-> common_lines_oe == '0 && row_out == '0)
      else $error("display lit with clock stopped");
   // *****
   // register bus
   // *****
   bus_idle_a:
      assert property (!(psel && penable) |-> !pslverr && prdata == '0) else $error("bus outputs outside access");
   bus_ready_a:
      assert property (psel && penable && paddr != REG_CMD_OFS |-> pready) else $error("wait on non-command access");
   bus_unmapped_a:
      assert property (psel && penable && paddr > REG_STATUS_OFS |-> pslverr) else $error("unmapped access accepted");
   cover property ($rose(power_down));
   cover property ($fell(power_down));
   cover property (common_lines_oe != '0);
   cover property (psel && penable && pslverr);
endmodule

/* File: ldcrc_cmd_rx.sv */
`timescale 1ns/100ps
module ldcrc_cmd_rx
   import ldcrc_pkg::*;
(
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   input  wire logic              enable,
   // serial pins
   input  wire logic              ser_cs_n,
   input  wire logic              ser_wr_n,
   input  wire logic              ser_data,
   // decoded command
   output ldcrc_pkg::ldcrc_cmd_s  cmd
);
   import ldcrc_pkg::*;

   logic [2:0] meta_q, sync_q;
   logic       wr_prev_q;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic       id_ok_q;
   logic       wr_rise;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         meta_q <= 3'h7;
         sync_q <= 3'h7;
      end
      else if (ce)
      begin
         meta_q <= {ser_cs_n, ser_wr_n, ser_data};
         sync_q <= meta_q;
      end

   assign wr_rise = sync_q[1] && !wr_prev_q;

   // data is clocked in on the rising edge of the write strobe
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         wr_prev_q <= 1'b1;
         cnt_q     <= 4'h0;
         shift_q   <= '0;
         id_ok_q   <= 1'b0;
         cmd       <= '0;
      end
      else if (ce)
      begin
         wr_prev_q <= sync_q[1];
         cmd.valid <= 1'b0;
         if (sync_q[2] || !enable)
         begin
            cnt_q   <= 4'h0;
            id_ok_q <= 1'b0;
         end
         else if (wr_rise)
         begin
            shift_q <= {shift_q[6:0], sync_q[0]};
            if (!id_ok_q && cnt_q == 4'h2)
            begin
               // a foreign mode id parks the counter until chip select rises,
               // so data-mode payload can never pass for a command
               id_ok_q <= ({shift_q[1:0], sync_q[0]} == MODE_ID_COMMAND);
               cnt_q   <= ({shift_q[1:0], sync_q[0]} == MODE_ID_COMMAND) ? 4'h0 : 4'hF;
            end
            else if (id_ok_q && cnt_q == 4'(CMD_BITS - 1))
            begin
               cmd.valid <= 1'b1;
               cmd.code  <= shift_q[7:0];
               cnt_q     <= 4'h0;
            end
            else if (cnt_q != 4'hF)
               cnt_q <= cnt_q + 4'h1;
         end
      end

endmodule

/* File: ldcrc_duty_gen.sv */
`timescale 1ns/100ps
module ldcrc_duty_gen
   import ldcrc_pkg::*;
#(
   parameter int NCOM = NUM_COMMONS
)
(
   // clock and reset
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            ce,
   // control
   input  wire logic            run,
   input  wire logic            tick,
   input  wire logic [3:0]      dim,
   // scan
   output logic      [NCOM-1:0] com_sel,
   output logic                 com_on
);
   import ldcrc_pkg::*;

   logic [8:0] slot_q;

   // stopping clears the scan so a restart begins on common 0
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         slot_q  <= '0;
         com_sel <= '0;
         com_on  <= 1'b0;
      end
      else if (ce)
      begin
         if (!run)
         begin
            slot_q  <= '0;
            com_sel <= '0;
            com_on  <= 1'b0;
         end
         else if (tick)
         begin
            if (slot_q == 9'(SLOT_TICKS - 1) || com_sel == '0)
            begin
               slot_q  <= '0;
               com_sel <= (com_sel == '0) ? NCOM'(1) : {com_sel[NCOM-2:0], com_sel[NCOM-1]};
            end
            else
               slot_q <= slot_q + 9'h1;
            com_on <= (slot_q < 9'((int'(dim) + 1) * DIM_STEP_TICKS));
         end
      end

endmodule

/* File: ldcrc_host_model.sv */
`timescale 1ns/100ps
module ldcrc_host_model
(
   // clock
   input wire logic pclk,
   // serial pins
   output logic     ser_cs_n,
   output logic     ser_wr_n,
   output logic     ser_data
);
   // data idles high, as the pin has a pull-up
   initial
   begin
      ser_cs_n = 1'b1;
      ser_wr_n = 1'b1;
      ser_data = 1'b1;
   end
   // pins are double-sampled, so each phase holds four cycles
   task automatic send(input logic [11:0] bits);
      int i;
      @(posedge pclk);
      ser_cs_n <= 1'b0;
      for (i = 11; i >= 0; i--)
      begin
         repeat (4) @(posedge pclk);
         ser_wr_n <= 1'b0;
         ser_data <= bits[i];
         repeat (4) @(posedge pclk);
         ser_wr_n <= 1'b1;
      end
      repeat (4) @(posedge pclk);
      ser_cs_n <= 1'b1;
      ser_data <= 1'b1;
   endtask
endmodule

/* File: ldcrc_pkg.sv */
package ldcrc_pkg;

   // ************************************************************
   // bus and register map
   // ************************************************************
   localparam int          APB_AW          = 12;
   localparam logic [11:0] REG_CTRL_OFS    = 12'h000;
   localparam logic [11:0] REG_CMD_OFS     = 12'h004;
   localparam logic [11:0] REG_STATUS_OFS  = 12'h008;
   localparam int          CTRL_XTAL_BIT   = 0;
   localparam int          CMD_CODE_LSB    = 0;
   localparam int          ST_SYS_EN_BIT   = 0;
   localparam int          ST_DISP_ON_BIT  = 1;
   localparam int          ST_CLK_EXT_BIT  = 2;
   localparam int          ST_CLK_RUN_BIT  = 3;
   localparam int          ST_PDOWN_BIT    = 4;
   localparam int          ST_BLINK_BIT    = 5;
   localparam int          ST_INIT_BIT     = 6;
   localparam int          ST_DIM_LSB      = 8;

   // ************************************************************
   // serial command mode and command codes
   // ************************************************************
   localparam logic [2:0]  MODE_ID_COMMAND = 3'h4;
   localparam int          CMD_BITS        = 9;
   localparam logic [7:0]  CMD_SYSTEM_DIS  = 8'h00;
   localparam logic [7:0]  CMD_SYSTEM_EN   = 8'h01;
   localparam logic [7:0]  CMD_DISPLAY_OFF = 8'h02;
   localparam logic [7:0]  CMD_DISPLAY_ON  = 8'h03;
   localparam logic [7:0]  CMD_BLINK_OFF   = 8'h08;
   localparam logic [7:0]  CMD_BLINK_ON    = 8'h09;
   localparam logic [7:0]  CMD_CLK_INT     = 8'h18;
   localparam logic [7:0]  CMD_CLK_EXT     = 8'h1C;
   localparam logic [3:0]  CMD_DIM_PREFIX  = 4'hA;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [3:0]  DIM_FULL        = 4'hF;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int          PCLK_KHZ        = 250000;
   localparam int          INT_OSC_KHZ     = 256;
   localparam int          OSC_DIV         = PCLK_KHZ / INT_OSC_KHZ;
   localparam int          INIT_DELAY_US   = 1000;
   localparam int          INIT_CYCLES     = INIT_DELAY_US * (PCLK_KHZ / 1000);
   localparam int          FRAME_TICKS     = 2624;
   localparam int          NUM_COMMONS     = 8;
   localparam int          SLOT_TICKS      = FRAME_TICKS / NUM_COMMONS;
   localparam int          DIM_STEP_TICKS  = 20;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
   } ldcrc_cmd_s;

endpackage

/* File: ldcrc_top.sv */
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module ldcrc_top
   import ldcrc_pkg::*;
#(
   parameter int NROW        = 44,
   parameter int INIT_CYC    = INIT_CYCLES,
   parameter int OSC_DIV_CYC = OSC_DIV
)
(
   // clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    ce,
   // apb slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [APB_AW-1:0]       paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   // serial command pins
   input  wire logic                    ser_cs_n,
   input  wire logic                    ser_wr_n,
   input  wire logic                    ser_data,
   // external clock / crystal pin
   input  wire logic                    external_timebase_pin,
   // display ram row data for the active common
   input  wire logic [NROW-1:0]         row_data,
   // led drive
   output logic      [NROW-1:0]         row_out,
   output logic      [NUM_COMMONS-1:0]  common_lines_out,
   output logic      [NUM_COMMONS-1:0]  common_lines_oe,
   // state
   output logic                         osc_enable,
   output logic                         timebase_run,
   output logic                         power_down,
   output logic                         blink_enable,
   output logic      [3:0]              dim_level
);
   import ldcrc_pkg::*;

   // ************************************************************
   // types and helpers
   // ************************************************************
   typedef enum logic [0:0] {INIT_WAIT, INIT_DONE} ldcrc_init_e;

   function automatic logic is_cmd(input ldcrc_cmd_s c, input logic [7:0] code);
      is_cmd = c.valid && c.code == code;
   endfunction

   ldcrc_init_e init_q;
   logic [17:0] init_cnt_q;
   logic        sys_en_q;
   logic        disp_on_q;
   logic        clk_ext_q;
   logic        blink_q;
   logic [3:0]  dim_q;
   logic        xtal_q;
   logic [9:0]  osc_cnt_q;
   logic        osc_tick_q;
   logic        ext_meta_q;
   logic        ext_sync_q;
   logic        ext_prev_q;
   logic        ext_tick;
   logic        sys_tick;
   logic        clk_run;
   logic        lit;
   logic        duty_run;
   logic [NUM_COMMONS-1:0] com_sel;
   logic        com_on;
   ldcrc_cmd_s  ser_cmd;
   ldcrc_cmd_s  apb_cmd;
   ldcrc_cmd_s  cmd;
   logic        apb_acc;
   logic        apb_wr;
   logic        hit_ctrl;
   logic        hit_cmd;
   logic        hit_status;
   logic        cmd_stall;
   logic [31:0] status_w;

   // ************************************************************
   // power-up initialisation
   // ************************************************************
   // serial traffic is held off until the wait ends, so an early host write cannot
   // leave the command decoder in a half-shifted state
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         init_q     <= INIT_WAIT;
         init_cnt_q <= '0;
      end
      else if (ce)
      begin
         unique case (init_q)
            INIT_WAIT:
            begin
               if (init_cnt_q >= 18'(INIT_CYC - 1))
                  init_q <= INIT_DONE;
               else
                  init_cnt_q <= init_cnt_q + 18'h1;
            end
            INIT_DONE:
               init_cnt_q <= init_cnt_q;
         endcase
      end

   // ************************************************************
   // command sources
   // ************************************************************
   ldcrc_cmd_rx u_rx
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .enable   (init_q == INIT_DONE),
      .ser_cs_n (ser_cs_n),
      .ser_wr_n (ser_wr_n),
      .ser_data (ser_data),
      .cmd      (ser_cmd)
   );

   assign apb_acc    = psel && penable;
   assign apb_wr     = apb_acc && pwrite;
   assign hit_ctrl   = paddr == REG_CTRL_OFS;
   assign hit_cmd    = paddr == REG_CMD_OFS;
   assign hit_status = paddr == REG_STATUS_OFS;

   // a software command waits while a serial one is being applied, and until
   // initialisation ends, so neither source is dropped when both arrive together
   assign cmd_stall   = apb_wr && hit_cmd && (ser_cmd.valid || init_q != INIT_DONE || !ce);
   assign pready      = !cmd_stall;
   assign apb_cmd.valid = apb_wr && hit_cmd && pready && pstrb[0];
   assign apb_cmd.code  = pwdata[CMD_CODE_LSB +: 8];
   assign cmd         = ser_cmd.valid ? ser_cmd : apb_cmd;

   // ************************************************************
   // mode state
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         sys_en_q <= 1'b0;
      else if (ce)
      begin
         if (is_cmd(cmd, CMD_SYSTEM_EN))
            sys_en_q <= 1'b1;
         else if (is_cmd(cmd, CMD_SYSTEM_DIS) && !clk_ext_q && !xtal_q)
            sys_en_q <= 1'b0;
      end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         disp_on_q <= 1'b0;
      else if (ce)
      begin
         if (is_cmd(cmd, CMD_DISPLAY_ON))
            disp_on_q <= 1'b1;
         else if (is_cmd(cmd, CMD_DISPLAY_OFF))
            disp_on_q <= 1'b0;
      end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         clk_ext_q <= 1'b0;
      else if (ce)
      begin
         if (is_cmd(cmd, CMD_CLK_EXT))
            clk_ext_q <= 1'b1;
         else if (is_cmd(cmd, CMD_CLK_INT))
            clk_ext_q <= 1'b0;
      end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         blink_q <= 1'b0;
      else if (ce)
      begin
         if (is_cmd(cmd, CMD_BLINK_ON))
            blink_q <= 1'b1;
         else if (is_cmd(cmd, CMD_BLINK_OFF))
            blink_q <= 1'b0;
      end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         dim_q <= DIM_FULL;
      else if (ce && cmd.valid && cmd.code[7:4] == CMD_DIM_PREFIX)
         dim_q <= cmd.code[3:0];

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         xtal_q <= 1'b0;
      else if (ce && apb_wr && hit_ctrl && pstrb[0])
         xtal_q <= pwdata[CTRL_XTAL_BIT];

   // ************************************************************
   // system clock sources
   // ************************************************************
   // the internal oscillator only runs while the system is enabled
   assign clk_run = clk_ext_q || xtal_q || sys_en_q;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         osc_cnt_q  <= '0;
         osc_tick_q <= 1'b0;
      end
      else if (ce)
      begin
         osc_tick_q <= 1'b0;
         if (!sys_en_q || clk_ext_q || xtal_q)
            osc_cnt_q <= '0;
         else if (osc_cnt_q == 10'(OSC_DIV_CYC - 1))
         begin
            osc_cnt_q  <= '0;
            osc_tick_q <= 1'b1;
         end
         else
            osc_cnt_q <= osc_cnt_q + 10'h1;
      end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end
      else if (ce)
      begin
         ext_meta_q <= external_timebase_pin;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end

   assign ext_tick = ext_sync_q && !ext_prev_q;
   assign sys_tick = (clk_ext_q || xtal_q) ? ext_tick : osc_tick_q;

   // ************************************************************
   // duty generator and drive
   // ************************************************************
   assign lit      = disp_on_q && clk_run;
   assign duty_run = lit;

   ldcrc_duty_gen #(
      .NCOM (NUM_COMMONS)
   ) u_duty
   (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .run     (duty_run),
      .tick    (sys_tick && clk_run),
      .dim     (dim_q),
      .com_sel (com_sel),
      .com_on  (com_on)
   );

   // commons are open drain: they sink when enabled and float otherwise
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         common_lines_oe  <= '0;
         common_lines_out <= '0;
         row_out          <= '0;
      end
      else if (ce)
      begin
         common_lines_oe  <= (lit && com_on) ? com_sel : '0;
         common_lines_out <= '0;
         row_out          <= (lit && com_on) ? row_data : '0;
      end

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         osc_enable   <= 1'b0;
         timebase_run <= 1'b0;
         power_down   <= 1'b1;
         blink_enable <= 1'b0;
         dim_level    <= DIM_FULL;
      end
      else if (ce)
      begin
         osc_enable   <= sys_en_q && !clk_ext_q && !xtal_q;
         timebase_run <= clk_run;
         // power-down needs the display off, the system disabled and neither the external clock nor the crystal selected
         power_down   <= !disp_on_q && !sys_en_q && !clk_ext_q && !xtal_q;
         blink_enable <= blink_q;
         dim_level    <= dim_q;
      end

   // ************************************************************
   // register read and response
   // ************************************************************
   always_comb
   begin
      status_w                 = '0;
      status_w[ST_SYS_EN_BIT]  = sys_en_q;
      status_w[ST_DISP_ON_BIT] = disp_on_q;
      status_w[ST_CLK_EXT_BIT] = clk_ext_q;
      status_w[ST_CLK_RUN_BIT] = clk_run;
      status_w[ST_PDOWN_BIT]   = power_down;
      status_w[ST_BLINK_BIT]   = blink_q;
      status_w[ST_INIT_BIT]    = init_q == INIT_WAIT;
      status_w[ST_DIM_LSB +: 4] = dim_q;
   end

   always_comb
   begin
      prdata  = '0;
      pslverr = 1'b0;
      if (apb_acc)
      begin
         if (hit_ctrl)
            prdata[CTRL_XTAL_BIT] = pwrite ? 1'b0 : xtal_q;
         else if (hit_status && !pwrite)
            prdata = status_w;
         else if (!(hit_cmd && pwrite))
            pslverr = 1'b1;
      end
   end

endmodule

/* File: led_driver_clock_reset_control_test.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module led_driver_clock_reset_control_test;
   import ldcrc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_pin;
   logic        ser_cs_n, ser_wr_n, ser_data, timebase_run, power_down, blink_enable;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed, r;
   logic [3:0]  pstrb, dim_level, m_dim, d;
   logic [43:0] row_data, row_out;
   logic [7:0]  common_lines_oe;
   logic        m_sys, m_disp, m_ext, m_xtal, m_blink, e, osc_en;
   int          n_mismatch, checks_done, i;

   ldcrc_top #(.INIT_CYC(20), .OSC_DIV_CYC(4)) dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .ser_cs_n, .ser_wr_n, .ser_data,
      .external_timebase_pin(ext_pin), .row_data, .row_out, .common_lines_out(), .common_lines_oe,
      .osc_enable(osc_en), .timebase_run, .power_down, .blink_enable, .dim_level);
   ldcrc_host_model host (.pclk, .ser_cs_n, .ser_wr_n, .ser_data);

   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) ext_pin <= ~ext_pin;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // *****
   // expected device state
   // *****
   function automatic void apply(input logic [7:0] c);
      case (c)
         CMD_SYSTEM_DIS:  m_sys = m_sys & (m_ext | m_xtal);
         CMD_SYSTEM_EN:   m_sys = 1'b1;
         CMD_DISPLAY_OFF: m_disp = 1'b0;
         CMD_DISPLAY_ON:  m_disp = 1'b1;
         CMD_BLINK_OFF:   m_blink = 1'b0;
         CMD_BLINK_ON:    m_blink = 1'b1;
         CMD_CLK_INT:     m_ext = 1'b0;
         CMD_CLK_EXT:     m_ext = 1'b1;
         default:         m_dim = c[3:0];
      endcase
   endfunction
   function automatic logic [31:0] status_of();
      logic [31:0] s;
      s = 32'h0;
      s[ST_SYS_EN_BIT] = m_sys;
      s[ST_DISP_ON_BIT] = m_disp;
      s[ST_CLK_EXT_BIT] = m_ext;
      s[ST_CLK_RUN_BIT] = m_sys | m_ext | m_xtal;
      s[ST_PDOWN_BIT] = ~(m_disp | m_sys | m_ext | m_xtal);
      s[ST_BLINK_BIT] = m_blink;
      s[ST_DIM_LSB +: 4] = m_dim;
      return s;
   endfunction
   // *****
   // bus tasks
   // *****
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // answer read mid-cycle, where it stands settled for the taking edge
      do
         @(negedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic check_state();
      logic [31:0] s;
      s = status_of();
      repeat (8) @(posedge pclk);
      apb(1'b0, REG_STATUS_OFS, 32'h0, r, e);
      `CHK("status", s, r)
      `CHK("power_down", s[ST_PDOWN_BIT], power_down)
      `CHK("timebase_run", s[ST_CLK_RUN_BIT], timebase_run)
      `CHK("dim_level", m_dim, dim_level)
      `CHK("blink", m_blink, blink_enable)
      `CHK("osc_enable", m_sys & ~m_ext & ~m_xtal, osc_en)
   endtask
   task automatic cmd(input logic [7:0] c, input logic ser);
      if (ser)
         host.send({MODE_ID_COMMAND, c, 1'b0});
      else
         apb(1'b1, REG_CMD_OFS, {24'h0, c}, r, e);
      apply(c);
      check_state();
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      #160000;
      n_mismatch++;
      complete_run();
   end
   // *****
   // main sequence
   // *****
   initial
   begin
      {presetn, psel, penable, pwrite, ext_pin, m_sys, m_disp, m_ext, m_xtal, m_blink} = '0;
      {paddr, pwdata, row_data, n_mismatch, checks_done} = '0;
      pstrb = 4'hF;
      m_dim = DIM_FULL;
      seed = 32'h157D6AAC;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, REG_STATUS_OFS, 32'h0, r, e);
      `CHK("status_rst", status_of() | 32'h40, r)
      apb(1'b0, 12'h00C, 32'h0, r, e);
      `CHK("unmapped", 1'b1, e)
      apb(1'b0, REG_CMD_OFS, 32'h0, r, e);
      `CHK("cmd_read", 1'b1, e)
      apb(1'b1, REG_STATUS_OFS, 32'hFFFF, r, e);
      `CHK("status_write", 1'b1, e)
      // the command write waits out initialisation; the serial host waits longer still
      cmd(CMD_SYSTEM_EN, 1'b0);
      cmd(CMD_DISPLAY_ON, 1'b1);
      row_data <= {12'(rnd()), rnd()};
      i = 0;
      while (common_lines_oe === 8'h00)
      begin
         @(posedge pclk);
         i++;
      end
      repeat (2) @(posedge pclk);
      `CHK("row_lit", row_data, row_out)
      for (i = 0; i < 4; i++)
      begin
         d = (i == 0) ? 4'h0 : 4'(rnd());
         cmd({CMD_DIM_PREFIX, d}, i[0]);
      end
      cmd({CMD_DIM_PREFIX, DIM_FULL}, 1'b1);
      cmd(CMD_BLINK_ON, 1'b1);
      cmd(CMD_BLINK_OFF, 1'b0);
      cmd(CMD_SYSTEM_DIS, 1'b1);
      `CHK("oe_stopped", 8'h00, common_lines_oe)
      `CHK("row_stopped", 44'h0, row_out)
      cmd(CMD_SYSTEM_EN, 1'b0);
      cmd(CMD_DISPLAY_OFF, 1'b0);
      cmd(CMD_SYSTEM_DIS, 1'b1);
      cmd(CMD_SYSTEM_EN, 1'b1);
      cmd(CMD_CLK_EXT, 1'b0);
      cmd(CMD_SYSTEM_DIS, 1'b0);
      cmd(CMD_CLK_INT, 1'b1);
      apb(1'b1, REG_CTRL_OFS, 32'h1, r, e);
      m_xtal = 1'b1;
      apb(1'b0, REG_CTRL_OFS, 32'h0, r, e);
      `CHK("ctrl_rd", 32'h1, r)
      cmd(CMD_SYSTEM_DIS, 1'b0);
      apb(1'b1, REG_CTRL_OFS, 32'h0, r, e);
      m_xtal = 1'b0;
      cmd(CMD_SYSTEM_DIS, 1'b1);
      // a frame with a foreign mode id must change nothing
      host.send({3'b101, CMD_SYSTEM_EN, 1'b0});
      check_state();
      pstrb <= 4'hE;
      apb(1'b1, REG_CTRL_OFS, 32'h1, r, e);
      pstrb <= 4'hF;
      apb(1'b0, REG_CTRL_OFS, 32'h0, r, e);
      `CHK("ctrl_strb", 32'h0, r)
      complete_run();
   end
endmodule

bind ldcrc_top ldcrc_chk #(.NROW(NROW)) chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready,
   .pslverr, .row_out, .common_lines_out, .common_lines_oe, .osc_enable, .timebase_run, .power_down,
   .blink_enable, .dim_level);
